//--- verilog/pcs_supervisor.sv
// Cycle-end servicing budget, power interruption handling and refresh conflict checks.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"
module pcs_supervisor (
  // Clock and reset.
  input  wire logic                ref_clk_in,
  input  wire logic                srst_in,
  // Operating mode and settings.
  input  wire pcs_pkg::pcs_mode_t  op_mode_in,
  input  wire logic                cfg_wr_in,
  input  wire logic                cfg_fixed_en_in,
  input  wire logic [7:0]          cfg_fixed_time_in,
  input  wire logic                cfg_pwr_task_en_in,
  input  wire logic [7:0]          cfg_pwr_delay_in,
  input  wire logic                cfg_err_detect_n_in,
  // Cycle phases from the CPU.
  input  wire logic                io_refresh_done_in,
  input  wire logic                cycle_start_in,
  // Power monitor pin.
  input  wire logic                low_voltage_in,
  // Interrupt-task unit accesses.
  input  wire logic                int_unit_access_in,
  input  wire logic [6:0]          int_unit_num_in,
  input  wire logic                cyc_refresh_dis_wr_in,
  input  wire logic [6:0]          cyc_refresh_dis_unit_in,
  input  wire logic                cyc_refresh_dis_val_in,
  input  wire logic                err_flag_clr_in,
  // Servicing outputs.
  output logic                     service_active_out,
  output logic [2:0]               service_sel_out,
  output logic [15:0]              service_budget_out,
  output logic [15:0]              last_cycle_ticks_out,
  output logic                     cycle_extend_out,
  // Power-off outputs.
  output logic                     program_stop_out,
  output logic                     pwr_task_run_out,
  // Status outputs.
  output logic                     cfg_rejected_out,
  output logic                     interrupt_task_error_flag_out
);
  import pcs_pkg::*;
  typedef struct packed {
    pcs_phase_t  phase;
    pcs_pwr_t    pwr;
    logic [1:0]  lv_sync;
    logic        fixed_en;
    logic [7:0]  fixed_time;
    logic        task_en;
    logic [7:0]  delay;
    logic [15:0] cyc_cnt;
    logic [15:0] last_cyc;
    logic [15:0] svc_cnt;
    logic [15:0] budget;
    logic [2:0]  svc_sel;
    logic [15:0] pwr_cnt;
    logic        extend;
    logic        stop;
    logic        task_run;
    logic        rejected;
    logic        err_flag;
    logic [95:0] refresh_dis;
    logic        active;
  } pcs_sup_st_t;
  pcs_sup_st_t s_q;
  pcs_sup_st_t s_d;
  logic        tick;
  logic        locked;
  logic [15:0] def_share;
  logic        conflict;

  pcs_tick u_tick (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .tick_out   (tick)
  );

  // Default share in 0.1 ms ticks, from a cycle length in ticks.
  function automatic logic [15:0] pcs_share(input logic [15:0] cyc);
    logic [31:0] prod;
    prod = 32'(cyc) * 32'(`PCS_SHARE_PCT);
    pcs_share = 16'(prod / 32'(`PCS_PCT_DIV));
  endfunction

  assign locked    = (op_mode_in != PCS_MODE_PROGRAM);
  assign def_share = pcs_share(s_q.last_cyc); // [RULE_02] [RULE_15]
  assign conflict  = int_unit_access_in && (int_unit_num_in < `PCS_NUM_UNITS) &&
                     !s_q.refresh_dis[int_unit_num_in];

  always_comb begin
    s_d = s_q;
    s_d.lv_sync = {s_q.lv_sync[0], low_voltage_in};
    s_d.rejected = 1'b0;
    // Settings other than cfg_err_detect_n_in and the cyclic refresh-disable bits are taken only in program mode.
    if (cfg_wr_in) begin
      if (locked) begin
        s_d.rejected = 1'b1; // [RULE_06] [RULE_11]
      end else begin
        s_d.fixed_en   = cfg_fixed_en_in;
        s_d.fixed_time = cfg_fixed_time_in; // [RULE_03]
        s_d.task_en    = cfg_pwr_task_en_in;
        s_d.delay      = (cfg_pwr_delay_in > `PCS_DELAY_MAX_TICKS) ?
                         `PCS_DELAY_MAX_TICKS : cfg_pwr_delay_in;
      end
    end
    if (cyc_refresh_dis_wr_in && (cyc_refresh_dis_unit_in < `PCS_NUM_UNITS)) begin
      s_d.refresh_dis[cyc_refresh_dis_unit_in] = cyc_refresh_dis_val_in;
    end
    // Set wins over clear.
    if (err_flag_clr_in) begin
      s_d.err_flag = 1'b0;
    end
    if (conflict && !cfg_err_detect_n_in) begin
      s_d.err_flag = 1'b1; // [RULE_12] [RULE_14]
    end
    if (tick) begin
      s_d.cyc_cnt = s_q.cyc_cnt + 16'h0001;
    end
    // Cycle phase sequence.
    case (s_q.phase)
      PCS_PROG: begin
        if (cycle_start_in) begin
          s_d.phase = PCS_REFRESH;
        end
      end
      PCS_REFRESH: begin
        if (io_refresh_done_in) begin
          s_d.phase   = PCS_SERVICE; // [RULE_01]
          s_d.svc_sel = 3'h0;
          s_d.svc_cnt = 16'h0000;
          s_d.budget  = s_q.fixed_en ? {8'h00, s_q.fixed_time} : def_share;
          s_d.extend  = s_q.fixed_en && ({8'h00, s_q.fixed_time} > def_share); // [RULE_05]
        end
      end
      PCS_SERVICE: begin
        if (tick) begin
          s_d.svc_cnt = s_q.svc_cnt + 16'h0001;
        end
        if (s_q.svc_cnt >= s_q.budget) begin
          s_d.svc_cnt = 16'h0000;
          if (s_q.svc_sel == `PCS_NUM_SVC - 3'h1) begin
            s_d.phase = PCS_DONE;
          end else begin
            s_d.svc_sel = s_q.svc_sel + 3'h1;
          end
        end
      end
      PCS_DONE: begin
        s_d.last_cyc = s_q.cyc_cnt; // [RULE_15]
        s_d.cyc_cnt  = 16'h0000;
        s_d.extend   = 1'b0;
        s_d.phase    = PCS_PROG;
      end
      default: s_d.phase = PCS_PROG;
    endcase
    // Registered copy of the servicing phase, so the output comes from a flip-flop.
    s_d.active = (s_d.phase == PCS_SERVICE); // [RULE_01]
    // Power interruption handling.
    case (s_q.pwr)
      PCS_PWR_OK: begin
        s_d.pwr_cnt = 16'h0000;
        if (s_q.lv_sync[1]) begin
          s_d.pwr = PCS_PWR_WAIT;
        end
      end
      PCS_PWR_WAIT: begin
        if (tick) begin
          s_d.pwr_cnt = s_q.pwr_cnt + 16'h0001;
        end
        if (!s_q.lv_sync[1]) begin
          s_d.pwr = PCS_PWR_OK;
        end else if (s_q.pwr_cnt >= {8'h00, s_q.delay}) begin
          s_d.stop = 1'b1; // [RULE_10]
          if (s_q.task_en) begin
            s_d.task_run = 1'b1; // [RULE_07]
            s_d.pwr      = PCS_PWR_TASK;
          end else begin
            s_d.pwr = PCS_PWR_DOWN;
          end
        end
      end
      PCS_PWR_TASK: begin
        if (tick) begin
          s_d.pwr_cnt = s_q.pwr_cnt + 16'h0001;
        end
        if (s_q.pwr_cnt >= `PCS_HOLD_MAX_TICKS) begin
          s_d.task_run = 1'b0; // [RULE_08]
          s_d.pwr      = PCS_PWR_DOWN;
        end
      end
      PCS_PWR_DOWN: s_d.pwr = PCS_PWR_DOWN;
      default: s_d.pwr = PCS_PWR_OK;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      s_q            <= '0;
      s_q.phase      <= PCS_PROG;
      s_q.pwr        <= PCS_PWR_OK;
      s_q.delay      <= `PCS_RST_DELAY;
      s_q.fixed_time <= `PCS_RST_FIXED;
    end else begin
      s_q <= s_d;
    end
  end

  assign service_active_out            = s_q.active;
  assign service_sel_out               = s_q.svc_sel;
  assign service_budget_out            = s_q.budget;
  assign last_cycle_ticks_out          = s_q.last_cyc;
  assign cycle_extend_out              = s_q.extend;
  assign program_stop_out              = s_q.stop;
  assign pwr_task_run_out              = s_q.task_run;
  assign cfg_rejected_out              = s_q.rejected;
  assign interrupt_task_error_flag_out = s_q.err_flag;

  service_after_refresh_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [RULE_01]
    (s_q.phase == PCS_REFRESH && io_refresh_done_in) |=> service_active_out)
    else $error("servicing did not follow I/O refresh");
  locked_cfg_kept_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [RULE_06]
    (cfg_wr_in && locked) |=> ($stable(s_q.fixed_time) && $stable(s_q.delay) && cfg_rejected_out))
    else $error("setting changed while locked");
  budget_source_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [RULE_02]
    (s_q.phase == PCS_REFRESH && io_refresh_done_in && !s_q.fixed_en)
      |=> service_budget_out == $past(def_share))
    else $error("default budget not 4 percent of last cycle");
  error_set_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [RULE_12]
    (conflict && !cfg_err_detect_n_in) |=> interrupt_task_error_flag_out)
    else $error("conflict did not set error flag");
  error_gated_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [RULE_14]
    (!interrupt_task_error_flag_out && cfg_err_detect_n_in) |=> !interrupt_task_error_flag_out)
    else $error("error flag set with detection off");
  task_bound_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [RULE_08]
    pwr_task_run_out |-> s_q.pwr_cnt <= `PCS_HOLD_MAX_TICKS)
    else $error("power-off task outlived hold time");
  no_task_disabled_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [RULE_07]
    $rose(program_stop_out) |-> (pwr_task_run_out == $past(s_q.task_en)))
    else $error("power-off task launch disagrees with enable");
  stop_after_delay_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // [RULE_10]
    $rose(program_stop_out) |-> $past(s_q.pwr_cnt) >= {8'h00, $past(s_q.delay)})
    else $error("program stopped before detection delay");
endmodule
`default_nettype wire

//--- verilog/pcs_defs.svh
// Constants for the cycle servicing and power-off supervisor.
// Functional notes
// [RULE_01] Servicing runs once per cycle, at cycle end, right after I/O refresh.
// [RULE_02] Default: each of five services gets 4% of previous cycle time.
// [RULE_03] Fixed option: one uniform time 0.0 to 25.5 ms in 0.1 ms steps.
// [RULE_04] Software keeps default share unless servicing is spread and delayed.
// [RULE_05] Servicing longer than default share lengthens the cycle accordingly.
// [RULE_06] Fixed servicing settings cannot change in run or monitor mode.
// [RULE_07] Task disabled: stop program on power loss; enabled: run power-off task.
// [RULE_08] Power-off task ends when hold time elapses, at most 10 ms.
// [RULE_09] User keeps power-off task under 10 ms minus detection delay.
// [RULE_10] Below 85% supply, wait set delay 0 to 10 ms, then stop program.
// [RULE_11] Detection delay and task enable are locked in run or monitor mode.
// [RULE_12] Interrupt-task refresh or memory access of cyclic unit raises error flag.
// [RULE_13] Program refreshes non-cyclic units at least every 11 seconds.
// [RULE_14] Conflict errors are detected only when detection setting is 0.
// [RULE_15] Cycle time is measured in 0.1 ms ticks; budget uses previous cycle.
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
`define PCS_CLK_PERIOD_PS 5000
`define PCS_TICK_US 100
`define PCS_TICK_CYC ((`PCS_TICK_US * 1000000) / `PCS_CLK_PERIOD_PS)
`define PCS_HOLD_MAX_TICKS 16'h0064
`define PCS_DELAY_MAX_TICKS 8'h64
`define PCS_FIXED_MAX 8'hFF
`define PCS_SHARE_PCT 16'h0004
`define PCS_PCT_DIV 16'h0064
`define PCS_NUM_SVC 3'h5
`define PCS_NUM_UNITS 7'h60
`define PCS_RST_DELAY 8'h00
`define PCS_RST_FIXED 8'h00
`endif

//--- verilog/pcs_pkg.sv
// Types for the cycle servicing and power-off supervisor.
package pcs_pkg;
  typedef enum logic [2:0] {
    PCS_PROG    = 3'b000,
    PCS_REFRESH = 3'b001,
    PCS_SERVICE = 3'b011,
    PCS_DONE    = 3'b010
  } pcs_phase_t;
  typedef enum logic [1:0] {
    PCS_PWR_OK   = 2'b00,
    PCS_PWR_WAIT = 2'b01,
    PCS_PWR_TASK = 2'b11,
    PCS_PWR_DOWN = 2'b10
  } pcs_pwr_t;
  typedef enum logic [1:0] {
    PCS_MODE_PROGRAM = 2'b00,
    PCS_MODE_MONITOR = 2'b01,
    PCS_MODE_RUN     = 2'b10
  } pcs_mode_t;
endpackage

//--- verilog/pcs_tick.sv
// Divider that marks every 0.1 ms on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"
module pcs_tick (
  // Clock and reset.
  input  wire logic ref_clk_in,
  input  wire logic srst_in,
  // Tick pulse.
  output logic      tick_out
);
  import pcs_pkg::*;
  localparam logic [15:0] LAST = 16'(`PCS_TICK_CYC - 1);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } pcs_tick_st_t;
  pcs_tick_st_t s_q;
  pcs_tick_st_t s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = (s_q.cnt == LAST);
    s_d.cnt = s_d.tick ? 16'h0000 : s_q.cnt + 16'h0001;
  end
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick_out = s_q.tick;
  tick_period_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    tick_out |=> !tick_out) else $error("tick pulse lasted more than one cycle"); // [RULE_15]
endmodule
`default_nettype wire

//--- verification/pcs_unit_model.sv
// Backplane unit model that issues interrupt-task accesses towards the supervisor.
`timescale 1ns/1ps
`default_nettype none
module pcs_unit_model (
  // Clock and request from the bench.
  input  wire logic       ref_clk_in,
  input  wire logic       req_in,
  input  wire logic [6:0] unit_in,
  // Access strobe and unit number.
  output logic            access_out,
  output logic [6:0]      unit_out
);
  // Outside a strobe the number shows the inverse, so a stale number never matches.
  always @(posedge ref_clk_in) begin
    access_out <= req_in;
    unit_out   <= req_in ? unit_in : ~unit_in;
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking testbench for the servicing and power-off supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pcs_pkg::*;
  logic clk = 0, rst = 1, cfg_wr = 0, fen = 0, ten = 0, detn = 0, iod = 0, cst = 0;
  logic lv = 0, req = 0, dwr = 0, dv = 0, clr = 0, sa, ext, stop, trun, rej, eflag, acc;
  logic [7:0] ftime = 8'h00, dly = 8'h00;
  logic [6:0] ru = 7'h00, du = 7'h00, aunit;
  logic [2:0] sel;
  logic [15:0] bud, lct;
  pcs_mode_t mode = PCS_MODE_PROGRAM;
  int err_total = 0, total_checks = 0, i, n;
  always #2.5 clk = ~clk;
  pcs_unit_model peer (.ref_clk_in(clk), .req_in(req), .unit_in(ru), .access_out(acc),
    .unit_out(aunit));
  pcs_supervisor dut (.ref_clk_in(clk), .srst_in(rst), .op_mode_in(mode), .cfg_wr_in(cfg_wr),
    .cfg_fixed_en_in(fen), .cfg_fixed_time_in(ftime), .cfg_pwr_task_en_in(ten),
    .cfg_pwr_delay_in(dly), .cfg_err_detect_n_in(detn), .io_refresh_done_in(iod),
    .cycle_start_in(cst), .low_voltage_in(lv), .int_unit_access_in(acc),
    .int_unit_num_in(aunit), .cyc_refresh_dis_wr_in(dwr), .cyc_refresh_dis_unit_in(du),
    .cyc_refresh_dis_val_in(dv), .err_flag_clr_in(clr), .service_active_out(sa),
    .service_sel_out(sel), .service_budget_out(bud), .last_cycle_ticks_out(lct),
    .cycle_extend_out(ext), .program_stop_out(stop), .pwr_task_run_out(trun),
    .cfg_rejected_out(rej), .interrupt_task_error_flag_out(eflag));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic reset_dut();
    @(posedge clk);
    rst <= 1;
    lv  <= 0;
    repeat (2) @(posedge clk);
    rst <= 0;
  endtask
  task automatic cfg(input pcs_mode_t m, input logic fe, input logic [7:0] ft, input logic te,
                     input logic dn);
    @(posedge clk);
    mode   <= m;
    fen    <= fe;
    ftime  <= ft;
    ten    <= te;
    detn   <= dn;
    cfg_wr <= 1;
    @(posedge clk);
    cfg_wr <= 0;
  endtask
  task automatic access(input logic [6:0] u, input logic expect_err);
    @(posedge clk);
    req <= 1;
    ru  <= u;
    @(posedge clk);
    req <= 0;
    repeat (5) @(negedge clk);
    chk("error_flag", {15'h0000, eflag}, {15'h0000, expect_err});
  endtask
  task automatic run_cycle(input logic [15:0] eb, input logic ee, input bit wait_end);
    int k;
    logic [2:0] s;
    @(posedge clk);
    cst <= 1;
    @(posedge clk);
    cst <= 0;
    @(posedge clk);
    iod <= 1;
    @(posedge clk);
    iod <= 0;
    for (k = 0; k < 4 && sa !== 1'b1; k++) @(negedge clk);
    chk("service_active", {15'h0000, sa}, 16'h0001);
    chk("service_sel", {13'h0000, sel}, 16'h0000);
    chk("service_budget", bud, eb);
    chk("cycle_extend", {15'h0000, ext}, {15'h0000, ee});
    if (wait_end) begin
      s = 3'h0;
      for (k = 0; k < 40 && sa === 1'b1; k++) begin
        @(negedge clk);
        if (sel === s + 3'h1) s = sel;
      end
      chk("last_service", {13'h0000, s}, 16'h0004);
      chk("service_end", {15'h0000, sa}, 16'h0000);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    run_cycle(16'h0000, 1'b0, 1'b1);
    for (i = 0; i < 2; i++) begin
      cfg(i == 0 ? PCS_MODE_MONITOR : PCS_MODE_RUN, 1'b1, 8'h19, 1'b1, 1'b0);
      for (n = 0; n < 4 && rej !== 1'b1; n++) @(negedge clk);
      chk("cfg_rejected", {15'h0000, rej}, 16'h0001);
      @(negedge clk);
      chk("cfg_rejected_pulse", {15'h0000, rej}, 16'h0000);
    end
    @(posedge clk);
    mode <= PCS_MODE_PROGRAM;
    run_cycle(16'h0000, 1'b0, 1'b1);
    cfg(PCS_MODE_PROGRAM, 1'b1, 8'h19, 1'b1, 1'b0);
    run_cycle(16'h0019, 1'b1, 1'b0);
    reset_dut();
    @(negedge clk);
    chk("reset_service", {15'h0000, sa}, 16'h0000);
    // A cycle held in program phase for about 2.5 ticks must report two whole ticks.
    repeat (50000) @(posedge clk);
    run_cycle(16'h0000, 1'b0, 1'b1);
    @(negedge clk);
    chk("last_cycle_ticks", lct, 16'h0002);
    access(7'h05, 1'b1);
    @(posedge clk);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    repeat (3) @(negedge clk);
    chk("error_clear", {15'h0000, eflag}, 16'h0000);
    @(posedge clk);
    dwr <= 1;
    du  <= 7'h05;
    dv  <= 1;
    @(posedge clk);
    dwr <= 0;
    access(7'h05, 1'b0);
    access(7'h60, 1'b0);
    cfg(PCS_MODE_PROGRAM, 1'b0, 8'h00, 1'b1, 1'b1);
    access(7'h06, 1'b0);
    for (i = 0; i < 2; i++) begin
      reset_dut();
      dly <= (i == 1) ? 8'h01 : 8'h00;
      cfg(PCS_MODE_PROGRAM, 1'b0, 8'h00, i == 0, 1'b0);
      lv <= 1;
      if (i == 1) begin
        repeat (10000) @(negedge clk);
        chk("delay_hold", {15'h0000, stop}, 16'h0000);
      end
      for (n = 0; n < 25000 && stop !== 1'b1; n++) @(negedge clk);
      chk("program_stop", {15'h0000, stop}, 16'h0001);
      chk("power_task", {15'h0000, trun}, {15'h0000, i == 0});
    end
    print_verdict();
  end
  initial begin
    #450000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
